// ===== design/qbff_params.svh
// Constants for the queue buffer control and frame forwarder.
// Overview of operation
// - One shared packet store of 5,952 words, 176 bytes each, holds every frame.
// - An internal memory manager picks the free words each incoming frame uses.
// - A frame dropped for excessive memory use is discarded whole, ignoring destinations.
// - Pause and discard trigger on per-port threshold and on total-use threshold.
// - Per-port taildrop limit acts only once total use exceeds a global level.
// - Per-port pause start and stop thresholds, gated by a global total level.
// - Report free word count and usage of one software-selected port.
// - Forwarder takes ingress queue heads and adds egress references, moving no data.
// - Forwarder sustains 78 to 156 million references per second, worst case 78M frames; this design gives at most one reference per cycle, 50M at 50 MHz.
// - Next ingress queue chosen by weighted round-robin; port mode also enables forwarding.
// - Drop-mode if ingress drop port, egress drop port, or analyzer drop flag.
// - Congested drop-mode copies are discarded; flow-control frames stall their queue.
// - Each ingress port selects ingress-focused or egress-focused discard statistics.
// - Ingress mode discards many copies at once; count once when N=0, M>0.
// - Egress mode counts each discarded copy per egress port, one per cycle.
// - Copies per frame are limited when ingress queue depth exceeds a threshold.
// - Copies discarded by forward pressure go into one shared counter.
// - CPU, mirror and learn-all requests use a 12-entry table of port and QoS.
// - Eight CPU queues map to a port; QoS ingress or per-queue, optional super priority.
// - Three mirror probes with own port and QoS; setting keeps mirrors of discarded frames.
// - Learn-all copies go to one or both stacking links plus optional extra port.
`ifndef QBFF_PARAMS_SVH
`define QBFF_PARAMS_SVH
`define QBFF_MEM_WORDS 13'h1740
`define QBFF_WORD_BYTES 8'hb0
`define QBFF_COPY_ENTRIES 12
`define QBFF_CPU_QUEUE_MASK_NUM 8
`define QBFF_MIRROR_NUM 3
`define QBFF_MIRROR_BASE 8
`define QBFF_LEARN_ENTRY 11
`define QBFF_LEARN_BITS 3
`define QBFF_IQ_DEPTH 8
`define QBFF_STAT_INGRESS 1'b1
`define QBFF_MIN_MREF_PER_S 78
`define QBFF_MAX_MREF_PER_S 156
`define QBFF_CLK_MHZ 50
`endif

// ===== design/qbff_pkg.sv
// Types shared by the queue buffer control and frame forwarder.
package qbff_pkg;
  typedef enum logic {
    QBFF_IDLE,
    QBFF_COPY
  } qbff_state_e;
endpackage : qbff_pkg

// ===== design/qbff_forwarder.sv
// Per-port ingress FIFO and the buffer control with frame forwarder.
`timescale 1ns/10ps
`include "qbff_params.svh"

module qbff_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `QBFF_IQ_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } qbff_fifo_s;
  qbff_fifo_s f_reg;
  qbff_fifo_s f_next;
  logic push;
  logic pop;
  assign in_ready_o = (f_reg.cnt != CW'(DEPTH));
  assign out_valid_o = (f_reg.cnt != '0);
  assign out_data_o = f_reg.mem[f_reg.rp];
  assign count_o = f_reg.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.mem[f_reg.wp] = in_data_i;
      f_next.wp = (f_reg.wp == AW'(DEPTH-1)) ? '0 : f_reg.wp + 1'b1;
    end
    if (pop) begin
      f_next.rp = (f_reg.rp == AW'(DEPTH-1)) ? '0 : f_reg.rp + 1'b1;
    end
    f_next.cnt = f_reg.cnt + CW'(push) - CW'(pop);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule : qbff_fifo

module qbff_forwarder #(
  parameter int NP = 12,
  parameter int NF = 10,
  parameter int PW = 4,
  parameter int WW = 13,
  parameter int QW = 3,
  parameter int WTW = 3,
  parameter int CNTW = 16,
  parameter int FD = `QBFF_IQ_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [PW-1:0] in_src_i,
  input wire logic [WW-1:0] in_words_i,
  input wire logic [NF-1:0] in_dest_i,
  input wire logic [`QBFF_CPU_QUEUE_MASK_NUM-1:0] in_cpu_queue_mask_i,
  input wire logic [1:0] in_mirror_i,
  input wire logic in_learn_all_i,
  input wire logic in_drop_i,
  input wire logic [QW-1:0] in_qos_i,
  input wire logic rel_valid_i,
  input wire logic [PW-1:0] rel_port_i,
  input wire logic [WW-1:0] rel_words_i,
  input wire logic [NP-1:0] cong_i,
  input wire logic [NP-1:0][WW-1:0] port_taildrop_limit_i,
  input wire logic [WW-1:0] total_taildrop_level_i,
  input wire logic [NP-1:0][WW-1:0] pause_start_i,
  input wire logic [NP-1:0][WW-1:0] pause_stop_i,
  input wire logic [WW-1:0] total_pause_level_i,
  input wire logic [NP-1:0] port_enable_i,
  input wire logic [NP-1:0] ingress_drop_i,
  input wire logic [NP-1:0] egress_drop_i,
  input wire logic [NP-1:0][WTW-1:0] round_robin_weight_i,
  input wire logic [NP-1:0] discard_stats_mode_i,
  input wire logic [NP-1:0][$clog2(FD+1)-1:0] copy_limit_threshold_i,
  input wire logic [NP-1:0][$clog2(FD+1)-1:0] copy_limit_copies_i,
  input wire logic [PW-1:0] usage_port_select_i,
  input wire logic [`QBFF_COPY_ENTRIES-1:0][PW-1:0] copy_port_i,
  input wire logic [`QBFF_COPY_ENTRIES-1:0][QW-1:0] copy_qos_i,
  input wire logic [`QBFF_COPY_ENTRIES-1:0] copy_ingress_qos_i,
  input wire logic [`QBFF_COPY_ENTRIES-1:0] copy_super_i,
  input wire logic [1:0] learn_stack_sel_i,
  input wire logic [PW-1:0] stack_port_a_i,
  input wire logic [PW-1:0] stack_port_b_i,
  input wire logic learn_extra_en_i,
  input wire logic [PW-1:0] learn_copy_extra_port_i,
  input wire logic [`QBFF_CPU_QUEUE_MASK_NUM-1:0] cpu_queue_disable_i,
  input wire logic mirror_on_discard_i,
  output logic alloc_valid_o,
  output logic [WW-1:0] alloc_base_o,
  output logic taildrop_o,
  output logic [NP-1:0] pause_o,
  output logic [WW-1:0] free_word_count_o,
  output logic [WW-1:0] selected_port_usage_o,
  output logic [NP-1:0][$clog2(FD+1)-1:0] ingress_queue_depth_o,
  output logic tx_valid_o,
  output logic [PW-1:0] tx_port_o,
  output logic [QW-1:0] tx_qos_o,
  output logic tx_super_o,
  output logic tx_discard_o,
  output logic [PW-1:0] tx_src_o,
  output logic frame_done_o,
  output logic [NP-1:0][CNTW-1:0] discard_count_o,
  output logic [31:0] copy_limit_drop_counter_o
);
  // --------------------------------------------------------------------
  // Local sizes and state.
  // --------------------------------------------------------------------
  localparam int CQW = $clog2(FD+1);
  localparam int DW = QW + 4 + `QBFF_CPU_QUEUE_MASK_NUM + NF;
  localparam int LB = NF + `QBFF_CPU_QUEUE_MASK_NUM;
  localparam int MB = LB + `QBFF_LEARN_BITS;
  localparam int NC = MB + 1;
  localparam int IW = $clog2(NC);
  localparam int SCW = $clog2(NC+1);

  typedef struct packed {
    logic in_rdy;
    logic stg_v;
    logic [PW-1:0] stg_src;
    logic [WW-1:0] stg_words;
    logic [DW-1:0] stg_desc;
    logic [WW-1:0] free;
    logic [NP-1:0][WW-1:0] usage;
    logic [NP-1:0] pause;
    logic [WW-1:0] aptr;
    logic alloc_v;
    logic [WW-1:0] abase;
    logic tdrop;
    logic [WW-1:0] sel_use;
    logic [NP-1:0][CQW-1:0] iqd;
    qbff_pkg::qbff_state_e st;
    logic [PW-1:0] rr;
    logic [WTW:0] credit;
    logic [PW-1:0] src;
    logic [NC-1:0] pend;
    logic [QW-1:0] qos;
    logic drop;
    logic [1:0] mir;
    logic [SCW-1:0] sw;
    logic dc;
    logic tx_v;
    logic [PW-1:0] tx_port;
    logic [QW-1:0] tx_qos;
    logic tx_super;
    logic tx_disc;
    logic [PW-1:0] tx_src;
    logic done;
    logic [NP-1:0][CNTW-1:0] dcnt;
    logic [31:0] fpcnt;
  } qbff_top_s;

  qbff_top_s s_reg;
  qbff_top_s s_next;
  logic [NP-1:0] push;
  logic [NP-1:0] pop;
  logic [NP-1:0] fifo_rdy;
  logic [NP-1:0] fifo_v;
  logic [NP-1:0][DW-1:0] fifo_d;
  logic [NP-1:0][CQW-1:0] fifo_cnt;
  logic [NC-1:0] disc_v;
  logic tail_hit;
  logic ev_fp;
  logic ev_stall;
  logic ev_edisc;
  logic ev_ibump;
  logic [WW-1:0] used;
  logic [WW-1:0] sel_now;

  // --------------------------------------------------------------------
  // Copy translation: pending bit to egress port and QoS.
  // --------------------------------------------------------------------
  // Bits: front ports, CPU queues, learn links A/B/extra, then the mirror.
  function automatic logic [PW-1:0] copy_port(input int b);
    if (b < NF) begin
      return PW'(b);
    end else if (b < LB) begin
      return copy_port_i[b-NF];
    end else if (b == LB) begin
      return stack_port_a_i;
    end else if (b == LB + 1) begin
      return stack_port_b_i;
    end else if (b == LB + 2) begin
      return learn_copy_extra_port_i;
    end
    return copy_port_i[`QBFF_MIRROR_BASE + int'(s_reg.mir) - 1];
  endfunction : copy_port

  function automatic logic [QW-1:0] copy_qos(input int b);
    if (b < NF) begin
      return s_reg.qos;
    end else if (b < LB) begin
      return copy_ingress_qos_i[b-NF] ? s_reg.qos : copy_qos_i[b-NF];
    end else if (b < MB) begin
      return copy_qos_i[`QBFF_LEARN_ENTRY];
    end
    return copy_qos_i[`QBFF_MIRROR_BASE + int'(s_reg.mir) - 1];
  endfunction : copy_qos

  function automatic logic drop_mode(input logic [PW-1:0] ep);
    return ingress_drop_i[s_reg.src] || egress_drop_i[ep] || s_reg.drop;
  endfunction : drop_mode

  function automatic logic [IW-1:0] first_bit(input logic [NC-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction : first_bit

  // --------------------------------------------------------------------
  // Ingress queues, one FIFO per source port.
  // --------------------------------------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_iq
    qbff_fifo #(
      .WIDTH(DW),
      .DEPTH(FD)
    ) u_iq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push[p]),
      .in_ready_o(fifo_rdy[p]),
      .in_data_i(s_reg.stg_desc),
      .out_valid_o(fifo_v[p]),
      .out_ready_i(pop[p]),
      .out_data_o(fifo_d[p]),
      .count_o(fifo_cnt[p])
    );
  end

  // In ingress-focused mode every congested drop-mode copy goes in one cycle.
  for (genvar b = 0; b < NC; b++) begin : g_disc
    assign disc_v[b] = s_reg.pend[b] && discard_stats_mode_i[s_reg.src] == `QBFF_STAT_INGRESS
      && cong_i[copy_port(b)] && drop_mode(copy_port(b));
  end

  assign used = WW'(`QBFF_MEM_WORDS) - s_reg.free;
  assign sel_now = s_reg.usage[usage_port_select_i];
  // Taildrop needs both the port limit and the total level; disabled ports drop too.
  assign tail_hit = (s_reg.usage[s_reg.stg_src] >= port_taildrop_limit_i[s_reg.stg_src]
    && used > total_taildrop_level_i) || !port_enable_i[s_reg.stg_src];

  // --------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------
  always_comb begin
    logic [WW:0] asum;
    logic [NC-1:0] cand;
    logic [IW-1:0] idx;
    logic [PW-1:0] ep;
    logic [PW-1:0] nrr;
    logic [DW-1:0] hd;
    asum = '0;
    cand = '0;
    idx = '0;
    ep = '0;
    nrr = '0;
    hd = '0;
    s_next = s_reg;
    push = '0;
    pop = '0;
    ev_fp = 1'b0;
    ev_stall = 1'b0;
    ev_edisc = 1'b0;
    ev_ibump = 1'b0;
    s_next.alloc_v = 1'b0;
    s_next.tdrop = 1'b0;
    s_next.tx_v = 1'b0;
    s_next.tx_disc = 1'b0;
    s_next.done = 1'b0;
    s_next.sel_use = sel_now;
    s_next.iqd = fifo_cnt;
    for (int p = 0; p < NP; p++) begin
      if (s_reg.usage[p] >= pause_start_i[p] && used >= total_pause_level_i) begin
        s_next.pause[p] = 1'b1;
      end else if (s_reg.usage[p] <= pause_stop_i[p]) begin
        s_next.pause[p] = 1'b0;
      end
    end
    if (rel_valid_i) begin
      s_next.free = s_next.free + rel_words_i;
      s_next.usage[rel_port_i] = s_next.usage[rel_port_i] - rel_words_i;
    end
    if (s_reg.stg_v) begin
      if (tail_hit) begin
        s_next.tdrop = 1'b1;
        s_next.stg_v = 1'b0;
      end else if (fifo_rdy[s_reg.stg_src]) begin
        push[s_reg.stg_src] = 1'b1;
        s_next.stg_v = 1'b0;
        s_next.alloc_v = 1'b1;
        s_next.abase = s_reg.aptr;
        s_next.free = s_next.free - s_reg.stg_words;
        s_next.usage[s_reg.stg_src] = s_next.usage[s_reg.stg_src] + s_reg.stg_words;
        // The store is a ring of words; allocation wraps at its end.
        asum = {1'b0, s_reg.aptr} + {1'b0, s_reg.stg_words};
        if (asum >= (WW+1)'(`QBFF_MEM_WORDS)) begin
          asum = asum - (WW+1)'(`QBFF_MEM_WORDS);
        end
        s_next.aptr = asum[WW-1:0];
      end
    end
    if (s_reg.in_rdy && in_valid_i) begin
      s_next.stg_v = 1'b1;
      s_next.stg_src = in_src_i;
      s_next.stg_words = in_words_i;
      s_next.stg_desc = {in_qos_i, in_drop_i, in_learn_all_i, in_mirror_i, in_cpu_queue_mask_i, in_dest_i};
    end
    s_next.in_rdy = !s_next.stg_v;
    unique case (s_reg.st)
      qbff_pkg::QBFF_IDLE: begin
        nrr = (s_reg.rr == PW'(NP-1)) ? '0 : s_reg.rr + 1'b1;
        if (fifo_v[s_reg.rr] && port_enable_i[s_reg.rr] && s_reg.credit != '0) begin
          pop[s_reg.rr] = 1'b1;
          hd = fifo_d[s_reg.rr];
          s_next.credit = s_reg.credit - 1'b1;
          s_next.src = s_reg.rr;
          s_next.qos = hd[DW-1 -: QW];
          s_next.drop = hd[DW-QW-1];
          s_next.mir = hd[LB+1:LB];
          s_next.sw = '0;
          s_next.dc = 1'b0;
          s_next.pend = {hd[LB+1:LB] != 2'h0,
            hd[LB+2] ? {learn_extra_en_i, learn_stack_sel_i} : 3'h0,
            hd[LB-1:NF] & ~cpu_queue_disable_i,
            hd[NF-1:0] & port_enable_i[NF-1:0]};
          s_next.st = qbff_pkg::QBFF_COPY;
        end else begin
          s_next.rr = nrr;
          s_next.credit = {1'b0, round_robin_weight_i[nrr]} + 1'b1;
        end
      end
      qbff_pkg::QBFF_COPY: begin
        cand = s_reg.pend & ~disc_v;
        s_next.pend = cand;
        if (disc_v != '0) begin
          s_next.dc = 1'b1;
        end
        if (cand != '0) begin
          idx = first_bit(cand);
          ep = copy_port(int'(idx));
          s_next.tx_port = ep;
          s_next.tx_qos = copy_qos(int'(idx));
          s_next.tx_super = idx >= IW'(NF) && idx < IW'(LB) && copy_super_i[int'(idx) - NF];
          s_next.tx_src = s_reg.src;
          if (int'(idx) == MB && s_reg.sw == '0 && s_next.dc && !mirror_on_discard_i) begin
            s_next.pend[idx] = 1'b0;
          end else if (s_reg.iqd[s_reg.src] > copy_limit_threshold_i[s_reg.src]
              && s_reg.sw >= SCW'(copy_limit_copies_i[s_reg.src])) begin
            ev_fp = 1'b1;
            s_next.pend[idx] = 1'b0;
            s_next.fpcnt = s_reg.fpcnt + 32'h1;
          end else if (cong_i[ep] && drop_mode(ep)) begin
            ev_edisc = 1'b1;
            s_next.pend[idx] = 1'b0;
            s_next.dc = 1'b1;
            s_next.tx_v = 1'b1;
            s_next.tx_disc = 1'b1;
            s_next.dcnt[ep] = s_reg.dcnt[ep] + 1'b1;
          end else if (cong_i[ep]) begin
            ev_stall = 1'b1;
            s_next.pend = s_reg.pend;
            s_next.dc = s_reg.dc;
          end else begin
            s_next.pend[idx] = 1'b0;
            s_next.sw = s_reg.sw + 1'b1;
            s_next.tx_v = 1'b1;
          end
        end
        if (s_next.pend == '0) begin
          s_next.st = qbff_pkg::QBFF_IDLE;
          s_next.done = 1'b1;
          if (discard_stats_mode_i[s_reg.src] == `QBFF_STAT_INGRESS && s_next.sw == '0 && s_next.dc) begin
            ev_ibump = 1'b1;
            s_next.dcnt[s_reg.src] = s_reg.dcnt[s_reg.src] + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.free <= WW'(`QBFF_MEM_WORDS);
      s_reg.in_rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs, all straight from the state register.
  // --------------------------------------------------------------------
  assign in_ready_o = s_reg.in_rdy;
  assign alloc_valid_o = s_reg.alloc_v;
  assign alloc_base_o = s_reg.abase;
  assign taildrop_o = s_reg.tdrop;
  assign pause_o = s_reg.pause;
  assign free_word_count_o = s_reg.free;
  assign selected_port_usage_o = s_reg.sel_use;
  assign ingress_queue_depth_o = s_reg.iqd;
  assign tx_valid_o = s_reg.tx_v;
  assign tx_port_o = s_reg.tx_port;
  assign tx_qos_o = s_reg.tx_qos;
  assign tx_super_o = s_reg.tx_super;
  assign tx_discard_o = s_reg.tx_disc;
  assign tx_src_o = s_reg.tx_src;
  assign frame_done_o = s_reg.done;
  assign discard_count_o = s_reg.dcnt;
  assign copy_limit_drop_counter_o = s_reg.fpcnt;

  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence stall_s;
    s_reg.st == qbff_pkg::QBFF_COPY ##0 ev_stall;
  endsequence
  sequence held_s;
    !tx_valid_o ##0 $stable(s_reg.pend);
  endsequence
  sequence edisc_s;
    ev_edisc ##1 tx_valid_o && tx_discard_o;
  endsequence

  tail_drop_a: assert property (s_reg.stg_v && tail_hit |=> taildrop_o && !alloc_valid_o)
    else $error("tail drop did not discard whole frame");
  alloc_free_a: assert property (s_reg.stg_v && !tail_hit && fifo_rdy[s_reg.stg_src] && !rel_valid_i
    |=> alloc_valid_o && free_word_count_o == $past(free_word_count_o) - $past(s_reg.stg_words))
    else $error("free count wrong after allocation");
  alloc_base_a: assert property (alloc_valid_o |-> alloc_base_o == $past(s_reg.aptr))
    else $error("allocation base is not the ring pointer");
  pause_start_a: assert property (s_reg.usage[0] >= pause_start_i[0] && used >= total_pause_level_i
    |=> pause_o[0])
    else $error("pause not raised at threshold");
  sel_usage_a: assert property (##1 selected_port_usage_o == $past(sel_now))
    else $error("selected port usage stale");
  stall_hold_a: assert property (stall_s |=> held_s)
    else $error("flow-control frame left head while congested");
  fp_count_a: assert property (ev_fp |=> copy_limit_drop_counter_o == $past(copy_limit_drop_counter_o) + 32'h1)
    else $error("forward pressure counter did not step");
  egress_disc_a: assert property (ev_edisc |-> edisc_s)
    else $error("egress discard not signalled");
  ingress_nodisc_a: assert property (ev_ibump |=> frame_done_o && !tx_valid_o)
    else $error("ingress discard count with a forwarded copy");
  wrr_enable_a: assert property (pop != '0 |-> port_enable_i[s_reg.rr] ##1 s_reg.st == qbff_pkg::QBFF_COPY)
    else $error("queue popped from disabled port");
endmodule : qbff_forwarder

// ===== bench/qbff_partner.sv
// Egress-side stand-in: congestion levels and slow buffer releases.
`timescale 1ns/10ps
module qbff_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] cong_set_i,
  input wire logic rel_req_i,
  input wire logic [3:0] rel_port_i,
  input wire logic [12:0] rel_words_i,
  output logic [11:0] cong_o,
  output logic rel_valid_o,
  output logic [3:0] rel_port_o,
  output logic [12:0] rel_words_o
);
  logic [1:0] dly_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_reg <= 2'h0;
    end else begin
      dly_reg <= {dly_reg[0], rel_req_i};
    end
  end
  assign cong_o = cong_set_i;
  // The last copy leaves two cycles late; outside the pulse the fields carry junk on purpose.
  assign rel_valid_o = dly_reg[1];
  assign rel_port_o = rel_valid_o ? rel_port_i : ~rel_port_i;
  assign rel_words_o = rel_valid_o ? rel_words_i : ~rel_words_i;
endmodule : qbff_partner

// ===== bench/qbff_forwarder_test.sv
// Self-checking bench for the buffer control and frame forwarder.
`timescale 1ns/10ps
module qbff_forwarder_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic iv = 1'b0, drp = 1'b0, ren = 1'b0, rdy, av, td, tv, tsu, tdis, fd, rv, lrn = 1'b0, lex = 1'b0, mod = 1'b0;
  logic [1:0] mir = 2'h0;
  logic [2:0] qos = 3'h5, tq;
  logic [3:0] src = 4'h0, rlp = 4'h0, rp, tp, ts;
  logic [7:0] cpm = 8'h00, cqd = 8'h08;
  logic [9:0] dst = 10'h000;
  logic [11:0] cong, pse, cset = 12'h000, pen = 12'hfff, zer = 12'h000, smode = 12'h040, csu = 12'h004;
  logic [12:0] wds = 13'h0001, rw, free, efree, ab, sup, tot = 13'h0000;
  logic [11:0][12:0] lim = '1, pst = '1;
  logic [11:0][3:0] cp, iqd, clt = '1;
  logic [11:0][2:0] cq;
  logic [11:0][15:0] dc;
  logic [31:0] fpc;
  int failures = 0;
  int compares = 0;
  logic [30:0] rows [4] = '{{4'h0, 10'h002, 13'h0003, 4'h1}, {4'h2, 10'h200, 13'h0001, 4'h9},
                            {4'h9, 10'h001, 13'h0010, 4'h0}, {4'h1, 10'h010, 13'h0007, 4'h4}};
  always #10 clk_i = ~clk_i;
  qbff_partner u_far (.clk_i, .rst_i, .cong_set_i(cset), .rel_req_i(ren), .rel_port_i(rlp),
    .rel_words_i(13'h0003), .cong_o(cong), .rel_valid_o(rv), .rel_port_o(rp), .rel_words_o(rw));
  qbff_forwarder u_dut (.clk_i, .rst_i, .in_valid_i(iv), .in_ready_o(rdy), .in_src_i(src), .in_words_i(wds),
    .in_dest_i(dst), .in_cpu_queue_mask_i(cpm), .in_mirror_i(mir), .in_learn_all_i(lrn), .in_drop_i(drp),
    .in_qos_i(qos), .rel_valid_i(rv), .rel_port_i(rp), .rel_words_i(rw), .cong_i(cong),
    .port_taildrop_limit_i(lim), .total_taildrop_level_i(tot), .pause_start_i(pst), .pause_stop_i(pst),
    .total_pause_level_i(tot), .port_enable_i(pen), .ingress_drop_i(zer), .egress_drop_i(zer),
    .round_robin_weight_i(cq), .discard_stats_mode_i(smode), .copy_limit_threshold_i(clt),
    .copy_limit_copies_i(clt), .usage_port_select_i(src), .copy_port_i(cp), .copy_qos_i(cq),
    .copy_ingress_qos_i(zer), .copy_super_i(csu), .learn_stack_sel_i(2'h3), .stack_port_a_i(4'ha),
    .stack_port_b_i(4'hb), .learn_extra_en_i(lex), .learn_copy_extra_port_i(4'h3),
    .cpu_queue_disable_i(cqd), .mirror_on_discard_i(mod), .alloc_valid_o(av), .alloc_base_o(ab),
    .taildrop_o(td), .pause_o(pse), .free_word_count_o(free), .selected_port_usage_o(sup),
    .ingress_queue_depth_o(iqd), .tx_valid_o(tv), .tx_port_o(tp), .tx_qos_o(tq), .tx_super_o(tsu),
    .tx_discard_o(tdis), .tx_src_o(ts), .frame_done_o(fd), .discard_count_o(dc), .copy_limit_drop_counter_o(fpc));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Event 0 is the admission answer, 1 a reference, 2 a finished frame; all are one-cycle pulses.
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    while (!(k == 0 ? (av | td) : (k == 1 ? tv : fd)) && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 60) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, k, 32'h1);
      results();
    end
  endtask : wait_ev
  task automatic send(input logic [3:0] s, input logic [9:0] d, input logic [12:0] w, input logic [7:0] c);
    @(negedge clk_i);
    src = s;
    dst = d;
    wds = w;
    cpm = c;
    iv = 1'b1;
    @(negedge clk_i);
    iv = 1'b0;
    wait_ev(0);
  endtask : send
  initial begin
    foreach (cp[i]) begin
      cp[i] = 4'(i);
      cq[i] = 3'(i);
    end
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    chk(rdy, 1'b1);
    chk(free, 13'h1740);
    $display("test reset done");
    efree = 13'h1740;
    foreach (rows[i]) begin
      send(rows[i][30:27], rows[i][26:17], rows[i][16:4], 8'h00);
      chk(ab, 13'h1740 - efree);
      efree = efree - rows[i][16:4];
      chk(av, 1'b1);
      chk(free, efree);
      wait_ev(1);
      chk(tp, rows[i][3:0]);
      chk(ts, rows[i][30:27]);
      $display("test row %0d done", i);
    end
    mir = 2'h2;
    send(4'h3, 10'h000, 13'h0002, 8'h0c);
    efree = efree - 13'h0002;
    wait_ev(1);
    chk(tp, 4'h2);
    chk({tq, tsu}, {3'h2, 1'b1});
    @(negedge clk_i);
    wait_ev(1);
    chk(tp, 4'h9);
    chk(fd, 1'b1);
    mir = 2'h0;
    $display("test copy table done");
    @(negedge clk_i);
    ren = 1'b1;
    @(negedge clk_i);
    ren = 1'b0;
    repeat (3) @(negedge clk_i);
    efree = efree + 13'h0003;
    chk(free, efree);
    $display("test release done");
    lim[4] = 13'h0000;
    tot = 13'h1740 - efree;
    send(4'h4, 10'h000, 13'h0002, 8'h00);
    chk(av, 1'b1);
    efree = efree - 13'h0002;
    send(4'h4, 10'h002, 13'h0002, 8'h00);
    chk(td, 1'b1);
    chk(free, efree);
    chk(sup, 13'h0002);
    pst[0] = 13'h0000;
    repeat (2) @(negedge clk_i);
    chk(pse[0], 1'b1);
    pst[0] = '1;
    repeat (2) @(negedge clk_i);
    chk(pse[0], 1'b0);
    $display("test taildrop done");
    cset = 12'h020;
    drp = 1'b1;
    mir = 2'h1;
    send(4'h6, 10'h020, 13'h0001, 8'h00);
    wait_ev(2);
    @(negedge clk_i);
    chk(dc[6], 16'h0001);
    mod = 1'b1;
    send(4'h6, 10'h020, 13'h0001, 8'h00);
    wait_ev(1);
    chk(tp, 4'h8);
    chk(dc[6], 16'h0001);
    mir = 2'h0;
    send(4'h7, 10'h020, 13'h0001, 8'h00);
    wait_ev(1);
    chk(tdis, 1'b1);
    repeat (2) @(negedge clk_i);
    chk(dc[5], 16'h0001);
    $display("test discard stats done");
    drp = 1'b0;
    send(4'h2, 10'h020, 13'h0001, 8'h00);
    repeat (20) @(negedge clk_i);
    cset = 12'h000;
    wait_ev(1);
    chk({tp, tdis}, {4'h5, 1'b0});
    $display("test stall done");
    lrn = 1'b1;
    lex = 1'b1;
    send(4'h0, 10'h000, 13'h0001, 8'h00);
    wait_ev(1);
    chk(tp, 4'ha);
    @(negedge clk_i);
    wait_ev(1);
    chk(tp, 4'hb);
    @(negedge clk_i);
    wait_ev(1);
    chk({tp, tq}, {4'h3, 3'h3});
    lrn = 1'b0;
    $display("test learn done");
    clt[8] = 4'h0;
    send(4'h8, 10'h001, 13'h0001, 8'h00);
    wait_ev(2);
    chk(fpc, 32'h1);
    chk(tv, 1'b0);
    chk(iqd[8], 4'h0);
    $display("test pressure done");
    results();
  end
endmodule : qbff_forwarder_test
